// ### logic/key_irq_pkg.sv
// Purpose: constants and types for the key input interrupt block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   all offsets are byte addresses
package key_irq_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] GROUP_A_FLAG_ADDR    = 8'h00;
   localparam logic [7:0] GROUP_B_FLAG_ADDR    = 8'h04;
   localparam logic [7:0] GROUP_A_MASK_ADDR    = 8'h08;
   localparam logic [7:0] GROUP_B_MASK_ADDR    = 8'h0c;
   localparam logic [7:0] GROUP_A_COMPARE_ADDR = 8'h10;
   localparam logic [7:0] PIN_STATE_ADDR       = 8'h14;
   localparam logic [7:0] IRQ_STATUS_ADDR      = 8'h18;
   localparam logic [7:0] IRQ_MASK_ADDR        = 8'h1c;

   // ==========================================================
   // field layout and reset values
   localparam int          GROUP_PINS      = 4;
   localparam int          ALL_PINS        = 2 * GROUP_PINS;
   localparam int          EVT_A_BIT       = 0;
   localparam int          EVT_B_BIT       = 1;
   localparam logic [3:0]  MASK_RESET      = 4'h0;
   localparam logic [3:0]  COMPARE_RESET   = 4'h0;
   localparam logic [7:0]  PIN_RESET       = 8'hff;
   localparam logic [1:0]  EVT_RESET       = 2'h0;
   localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

   // ==========================================================
   // state of the block, registered as one word
   typedef struct packed {
      logic [7:0]  sync1;
      logic [7:0]  sync2;
      logic [7:0]  sync3;
      logic [7:0]  pin;
      logic        cond_a;
      logic        cond_b;
      logic        group_a_irq_flag;
      logic        group_b_irq_flag;
      logic [3:0]  group_a_irq_mask_bits;
      logic [3:0]  group_b_irq_mask_bits;
      logic [3:0]  group_a_compare_level_bits;
      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic        irq;
      logic        group_a_req;
      logic        group_b_req;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } key_state_t;

endpackage : key_irq_pkg

// ### logic/key_irq.sv
// Purpose: key input pin interrupt logic with an APB register file
// Assumes: pins are asynchronous; one clock clk_sys at 100 MHz
// Notes:   no wait state on any APB access; ready in the first access cycle
//
// Behaviour
// - falling-edge pin sets flag on high-to-low
// - rising-edge pin sets flag on low-to-high
// - active level is low or high per edge
// - mask re-set at active level sets flag
// - compare rewrite at active level may set
// - reading flag clears it; reset clears too
// - masks read/write, one enables, reset zero
// - group a flags unmasked compare mismatch
// - group b flags unmasked falling edge
`timescale 1ns/10ps

module key_irq
   import key_irq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [3:0]  group_a_input_pins,
   input  wire logic [3:0]  group_b_input_pins,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             group_a_irq_req,
   output logic             group_b_irq_req,
   output logic             irq
);

   // ==========================================================
   // reset release
   logic [1:0]  rst_sync;
   logic        rst_ok;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   assign rst_ok = rst_sync[1];

   // ==========================================================
   // state
   key_state_t  state;
   key_state_t  next_state;

   logic [7:0]  agree;
   logic        cond_a;
   logic        cond_b;
   logic        set_a;
   logic        set_b;
   logic        access;
   logic        rd_done;
   logic        wr_done;
   logic        hit;
   logic [31:0] rd_word;

   // ==========================================================
   // next state
   always_comb
   begin
      next_state = state;

      // three-stage pin capture
      next_state.sync1 = {group_b_input_pins, group_a_input_pins};
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      // a pin changes only once stages two and three agree
      agree = ~(state.sync2 ^ state.sync3);
      next_state.pin = (agree & state.sync3) | (~agree & state.pin);

      // a compare bit of 1 expects high: its active level is low
      // and the flag comes on the falling edge, else the rising
      cond_a = |(state.group_a_irq_mask_bits &
                 (state.pin[GROUP_PINS-1:0] ^
                  state.group_a_compare_level_bits));
      // group b is active low
      cond_b = |(state.group_b_irq_mask_bits &
                 ~state.pin[ALL_PINS-1:GROUP_PINS]);
      next_state.cond_a = cond_a;
      next_state.cond_b = cond_b;
      // condition rising covers the pin edge, a mask being
      // set while active and a compare rewrite while active
      set_a = cond_a & ~state.cond_a;
      set_b = cond_b & ~state.cond_b;

      // ---------------- apb decode
      access  = psel & penable & state.pready;
      rd_done = access & ~pwrite;
      wr_done = access & pwrite & ~state.pslverr;
      hit     = 1'b1;
      rd_word = RDATA_ZERO;
      unique case (paddr)
         GROUP_A_FLAG_ADDR:
            rd_word[0] = state.group_a_irq_flag;
         GROUP_B_FLAG_ADDR:
            rd_word[0] = state.group_b_irq_flag;
         GROUP_A_MASK_ADDR:
            rd_word[GROUP_PINS-1:0] = state.group_a_irq_mask_bits;
         GROUP_B_MASK_ADDR:
            rd_word[GROUP_PINS-1:0] = state.group_b_irq_mask_bits;
         GROUP_A_COMPARE_ADDR:
            rd_word[GROUP_PINS-1:0] = state.group_a_compare_level_bits;
         PIN_STATE_ADDR:
            rd_word[ALL_PINS-1:0] = state.pin;
         IRQ_STATUS_ADDR:
            rd_word[1:0] = state.irq_status;
         IRQ_MASK_ADDR:
            rd_word[1:0] = state.irq_mask;
         default:
            hit = 1'b0;
      endcase

      // answer in the cycle after setup
      next_state.pready = psel & ~penable;
      if (psel & ~penable)
      begin
         next_state.pslverr = ~hit;
         next_state.prdata  = pwrite ? RDATA_ZERO : rd_word;
      end
      else if (access)
      begin
         next_state.pslverr = 1'b0;
      end

      // ---------------- flags: set beats the read clear, and
      // a read clears only what it returned so no set is lost
      next_state.group_a_irq_flag = set_a | (state.group_a_irq_flag &
         ~(rd_done & (paddr == GROUP_A_FLAG_ADDR) &
           state.prdata[0]));
      next_state.group_b_irq_flag = set_b | (state.group_b_irq_flag &
         ~(rd_done & (paddr == GROUP_B_FLAG_ADDR) &
           state.prdata[0]));

      // ---------------- writes
      if (wr_done)
      begin
         unique case (paddr)
            GROUP_A_MASK_ADDR:
               next_state.group_a_irq_mask_bits =
                  pwdata[GROUP_PINS-1:0];
            GROUP_B_MASK_ADDR:
               next_state.group_b_irq_mask_bits =
                  pwdata[GROUP_PINS-1:0];
            GROUP_A_COMPARE_ADDR:
               next_state.group_a_compare_level_bits =
                  pwdata[GROUP_PINS-1:0];
            IRQ_MASK_ADDR:
               next_state.irq_mask = pwdata[1:0];
            default:
               next_state.irq_mask = state.irq_mask;
         endcase
      end

      // ---------------- sticky events, write one to clear
      next_state.irq_status = state.irq_status &
         ~((wr_done && paddr == IRQ_STATUS_ADDR) ?
           pwdata[1:0] : EVT_RESET);
      next_state.irq_status[EVT_A_BIT] =
         next_state.irq_status[EVT_A_BIT] | set_a;
      next_state.irq_status[EVT_B_BIT] =
         next_state.irq_status[EVT_B_BIT] | set_b;
      next_state.irq = |(next_state.irq_status & next_state.irq_mask);

      // cpu request per group
      next_state.group_a_req = next_state.group_a_irq_flag &
         (|next_state.group_a_irq_mask_bits);
      next_state.group_b_req = next_state.group_b_irq_flag &
         (|next_state.group_b_irq_mask_bits);
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_sys or negedge rst_ok)
   begin
      if (!rst_ok)
      begin
         state.sync1                      <= PIN_RESET;
         state.sync2                      <= PIN_RESET;
         state.sync3                      <= PIN_RESET;
         state.pin                        <= PIN_RESET;
         state.cond_a                     <= 1'b0;
         state.cond_b                     <= 1'b0;
         state.group_a_irq_flag           <= 1'b0;
         state.group_b_irq_flag           <= 1'b0;
         state.group_a_irq_mask_bits      <= MASK_RESET;
         state.group_b_irq_mask_bits      <= MASK_RESET;
         state.group_a_compare_level_bits <= COMPARE_RESET;
         state.irq_status                 <= EVT_RESET;
         state.irq_mask                   <= EVT_RESET;
         state.irq                        <= 1'b0;
         state.group_a_req                <= 1'b0;
         state.group_b_req                <= 1'b0;
         state.pready                     <= 1'b0;
         state.pslverr                    <= 1'b0;
         state.prdata                     <= RDATA_ZERO;
      end
      else
         state <= next_state;
   end

   // ==========================================================
   // outputs
   assign prdata          = state.prdata;
   assign pready          = state.pready;
   assign pslverr         = state.pslverr;
   assign group_a_irq_req = state.group_a_req;
   assign group_b_irq_req = state.group_b_req;
   assign irq             = state.irq;

endmodule : key_irq

// ### tb/key_pins.sv
// Purpose: far side model, key switches on both pin groups
// Assumes: bench commands levels just after a clock edge
// Notes:   pins are unrelated to the clock in hardware
`timescale 1ns/10ps
module key_pins
(
   input  wire logic [3:0] want_a,
   input  wire logic [3:0] want_b,
   output logic      [3:0] group_a_input_pins,
   output logic      [3:0] group_b_input_pins
);
   // ==========================================================
   // switches: contacts settle at once, so no rise time is modelled
   assign group_a_input_pins = want_a;
   assign group_b_input_pins = want_b;
endmodule : key_pins

// ### tb/key_irq_props.sv
// Purpose: port assertions for key_irq
// Assumes: apb master keeps the no wait state contract
// Notes:   bound at the foot of this file
`timescale 1ns/10ps
module key_irq_props
   import key_irq_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic [3:0]  group_a_input_pins,
   input wire logic [3:0]  group_b_input_pins,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        group_a_irq_req,
   input wire logic        group_b_irq_req
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // bus and flags
   a_ready_after_setup: assert property (
      psel && !penable |=> pready) else $error("ready missing");
   a_ready_one_pulse: assert property (
      pready |=> !pready) else $error("ready too long");
   a_ready_in_access: assert property (
      pready |-> psel && penable) else $error("ready outside access");
   a_error_zero_data: assert property (
      pslverr |-> pready && prdata == 32'h0) else $error("bad error data");
   a_read_clears_a: assert property (
      pready && !pwrite && paddr == GROUP_A_FLAG_ADDR && prdata[0]
      |=> !group_a_irq_req) else $error("flag a not cleared");
   a_read_clears_b: assert property (
      pready && !pwrite && paddr == GROUP_B_FLAG_ADDR && prdata[0]
      |=> !group_b_irq_req) else $error("flag b not cleared");
   // a pin change must cross the synchroniser before any request
   a_sync_delay_a: assert property (
      $changed(group_a_input_pins) |=> !$rose(group_a_irq_req) [*3])
      else $error("group a too fast");
   a_sync_delay_b: assert property (
      $changed(group_b_input_pins) |=> !$rose(group_b_irq_req) [*3])
      else $error("group b too fast");
   c_req_a: cover property ($rose(group_a_irq_req));
   c_req_b: cover property ($rose(group_b_irq_req));
   c_error: cover property (pslverr);
endmodule : key_irq_props

bind key_irq key_irq_props u_props (.clk_sys(clk_sys), .rstn(rstn),
   .group_a_input_pins(group_a_input_pins), .psel(psel),
   .group_b_input_pins(group_b_input_pins), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .group_a_irq_req(group_a_irq_req),
   .group_b_irq_req(group_b_irq_req));

// ### tb/input_port_interrupt_logic_test.sv
// Purpose: self-checking bench for key_irq
// Assumes: apb answers with no wait state, ready in the first access cycle
// Notes:   pins settle within 10 edges of a change
`timescale 1ns/10ps
module input_port_interrupt_logic_test;
   import key_irq_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [3:0]  want_a  = 4'h0;
   logic [3:0]  want_b  = 4'hf;
   logic [3:0]  pins_a, pins_b;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, req_a, req_b, irq;
   int          n_errors = 0;
   int          check_count = 0;
   logic [40:0] rows [9];
   key_pins far (.want_a(want_a), .want_b(want_b),
      .group_a_input_pins(pins_a), .group_b_input_pins(pins_b));
   key_irq dut (.clk_sys(clk_sys), .rstn(rstn),
      .group_a_input_pins(pins_a), .group_b_input_pins(pins_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .group_a_irq_req(req_a),
      .group_b_irq_req(req_b), .irq(irq));
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // idle edge at the end keeps psel from toggling twice in one step
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rchk
   task automatic final_report;
      $display("checks=%0d errors=%0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   initial
   begin
      tick(5000);
      n_errors++;
      final_report();
   end
   // ==========================================================
   // tests
   initial
   begin
      rows[0] = {GROUP_A_FLAG_ADDR, 32'h0, 1'b0};
      rows[1] = {GROUP_B_FLAG_ADDR, 32'h0, 1'b0};
      rows[2] = {GROUP_A_MASK_ADDR, 28'h0, MASK_RESET, 1'b0};
      rows[3] = {GROUP_B_MASK_ADDR, 28'h0, MASK_RESET, 1'b0};
      rows[4] = {GROUP_A_COMPARE_ADDR, 28'h0, COMPARE_RESET, 1'b0};
      rows[5] = {PIN_STATE_ADDR, 32'h0000_00f0, 1'b0};
      rows[6] = {IRQ_STATUS_ADDR, 32'h0, 1'b0};
      rows[7] = {IRQ_MASK_ADDR, 32'h0, 1'b0};
      rows[8] = {8'h20, RDATA_ZERO, 1'b1};
      tick(12);
      rstn <= 1'b1;
      tick(6);
      foreach (rows[i])
      begin
         apb(1'b0, rows[i][40:33], 32'h0);
         chk(rd, rows[i][32:1]);
         chk(32'(er), 32'(rows[i][0]));
      end
      apb(1'b1, GROUP_A_MASK_ADDR, 32'hffff_ffff);
      rchk(GROUP_A_MASK_ADDR, 32'h0000_000f);
      apb(1'b1, GROUP_A_MASK_ADDR, 32'h0);
      $display("test registers done");
      apb(1'b1, IRQ_MASK_ADDR, 32'h3);
      apb(1'b1, GROUP_B_MASK_ADDR, 32'h1);
      want_b <= 4'hd;
      tick(10);
      chk(32'(req_b), 32'h0);
      want_b <= 4'hc;
      tick(10);
      chk(32'({irq, req_b}), 32'h3);
      rchk(IRQ_STATUS_ADDR, 32'h2);
      rchk(GROUP_B_FLAG_ADDR, 32'h1);
      rchk(GROUP_B_FLAG_ADDR, 32'h0);
      apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
      tick(2);
      chk(32'(irq), 32'h0);
      $display("test group b edge done");
      apb(1'b1, GROUP_B_MASK_ADDR, 32'h0);
      apb(1'b1, GROUP_B_MASK_ADDR, 32'h1);
      tick(4);
      rchk(GROUP_B_FLAG_ADDR, 32'h1);
      $display("test mask reset at active done");
      apb(1'b1, GROUP_A_MASK_ADDR, 32'h1);
      want_a <= 4'h1;
      tick(10);
      chk(32'(req_a), 32'h1);
      rchk(GROUP_A_FLAG_ADDR, 32'h1);
      apb(1'b1, GROUP_A_MASK_ADDR, 32'h0);
      want_a <= 4'h3;
      apb(1'b1, GROUP_A_COMPARE_ADDR, 32'h3);
      tick(10);
      apb(1'b1, GROUP_A_MASK_ADDR, 32'h2);
      tick(4);
      rchk(GROUP_A_FLAG_ADDR, 32'h0);
      want_a <= 4'h1;
      tick(10);
      rchk(GROUP_A_FLAG_ADDR, 32'h1);
      apb(1'b1, GROUP_A_COMPARE_ADDR, 32'h1);
      apb(1'b1, GROUP_A_COMPARE_ADDR, 32'h3);
      tick(4);
      chk(32'(req_a), 32'h1);
      apb(1'b1, GROUP_A_MASK_ADDR, 32'h0);
      tick(2);
      chk(32'(req_a), 32'h0);
      rchk(GROUP_A_FLAG_ADDR, 32'h1);
      $display("test group a done");
      // mid-run reset: state must return to its reset values
      apb(1'b1, GROUP_B_MASK_ADDR, 32'h1);
      rstn <= 1'b0;
      tick(2);
      chk(32'({irq, req_a, req_b}), 32'h0);
      rstn <= 1'b1;
      tick(4);
      rchk(GROUP_A_MASK_ADDR, 32'h0);
      rchk(GROUP_B_MASK_ADDR, 32'h0);
      rchk(GROUP_A_FLAG_ADDR, 32'h0);
      rchk(GROUP_B_FLAG_ADDR, 32'h0);
      $display("test mid-run reset done");
      final_report();
   end
endmodule : input_port_interrupt_logic_test
